// ---- src/rvg_defines.vh ----
// constants shared by the random value generator files
// assumes inclusion by bare name from every design file
`ifndef RVG_DEFINES_VH
`define RVG_DEFINES_VH

// register word offsets (byte addresses)
`define RVG_ADDR_CTRL 8'h00
`define RVG_ADDR_STAT 8'h04
`define RVG_ADDR_VALUE 8'h08
`define RVG_ADDR_IRQ_STAT 8'h0c
`define RVG_ADDR_IRQ_EN 8'h10
`define RVG_ADDR_IRQ_CLR 8'h14

// control register fields
`define RVG_CTRL_START_BIT 0
`define RVG_CTRL_STOP_BIT 1
`define RVG_CTRL_MODE_BIT 2
`define RVG_CTRL_IRQEN_BIT 3

// mode encodings
`define RVG_ONE_VALUE_MODE 1'b0
`define RVG_FREE_RUNNING_MODE 1'b1

// status fields
`define RVG_STAT_AVAIL_BIT 0
`define RVG_STAT_RUN_BIT 1
`define RVG_STAT_MODE_BIT 2

// interrupt event bits
`define RVG_IRQ_NEW_BIT 0
`define RVG_IRQ_OVR_BIT 1

// timing
`define RVG_CLK_HZ 25000000
`define RVG_SLOW_HZ 32768
`define RVG_PERIOD_US 256
`define RVG_SLOW_DIV ((`RVG_CLK_HZ + `RVG_SLOW_HZ - 1) / `RVG_SLOW_HZ)
`define RVG_PERIOD_CYC ((`RVG_PERIOD_US * (`RVG_CLK_HZ / 1000)) / 1000)
`define RVG_LFSR_SEED 16'hace1

`endif

// ---- src/rvg_lfsr.v ----
// free running 16-bit lfsr entropy source
// stepped by the low-speed tick, mixed with bus activity by the top
`timescale 1ns/1ps
`include "rvg_defines.vh"
module rvg_lfsr (
    // clock and reset
    input wire mclk_i,
    input wire srst_i,
    // control
    input wire step_i,
    input wire stir_i,
    // state
    output reg [15:0] state_o
);
    wire fb;
    assign fb = state_o[15] ^ state_o[13] ^ state_o[12] ^ state_o[10] ^ stir_i;

    always @(posedge mclk_i) begin
        if (srst_i) begin
            state_o <= `RVG_LFSR_SEED;
        end else if (step_i) begin
            // zero state would lock the lfsr
            state_o <= (state_o == 16'h0000) ? `RVG_LFSR_SEED : {state_o[14:0], fb};
        end
    end
endmodule

// ---- src/rvg_slow_tick.v ----
// divider making the low-speed enable pulse
// assumes one system clock; output is a single-cycle pulse
`timescale 1ns/1ps
`include "rvg_defines.vh"
module rvg_slow_tick #(
    parameter DIV = `RVG_SLOW_DIV
) (
    // clock and reset
    input wire mclk_i,
    input wire srst_i,
    // pulse
    output reg tick_o
);
    reg [15:0] cnt;

    always @(posedge mclk_i) begin
        if (srst_i) begin
            cnt <= 16'h0000;
            tick_o <= 1'b0;
        end else if (cnt == DIV[15:0] - 16'h0001) begin
            cnt <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            cnt <= cnt + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule

// ---- src/rvg_top.v ----
// random value generator with register port and interrupt
// Summary of operation
// - values are 16 bits, read in full
// - one-value mode delivers one value, halts
// - free-running mode delivers every 256 us plus the wait for the next slow tick
// - enabled interrupt raised per new value
// - pollable flag shows unconsumed new value
// - flag high when waiting, low otherwise
// - polling leaves value and flag untouched
// - value read returns latest produced value
// - stop command halts free-running generation
// - mode and irq enable latched at start
// - generation paced by the 32 kHz domain
// assumes a single-cycle strobe master on mclk_i
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "rvg_defines.vh"
module rvg_top #(
    parameter PERIOD_CYC = `RVG_PERIOD_CYC,
    parameter SLOW_DIV = `RVG_SLOW_DIV
) (
    // clock and reset
    input wire mclk_i,
    input wire srst_i,
    // register port
    input wire [7:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    // interrupt and status
    output reg irq_o,
    output reg running_o
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_RUN = 2'h2;

    reg [1:0] state;
    reg [1:0] next_state;
    reg mode;
    reg start_irq_en;
    reg avail;
    reg [15:0] value;
    reg [15:0] next_value;
    reg [31:0] period_cnt;
    reg [1:0] irq_stat;
    reg [1:0] irq_en;
    reg [1:0] next_irq_stat;
    reg next_avail;
    reg produce;
    wire slow_tick;
    wire [15:0] lfsr_q;
    wire wr_ctrl;
    wire start_cmd;
    wire stop_cmd;
    wire value_rd;

    function [31:0] rvg_word;
        input [15:0] v;
        begin
            rvg_word = {16'h0000, v};
        end
    endfunction

    assign wr_ctrl = wr_i && (addr_i == `RVG_ADDR_CTRL);
    assign start_cmd = wr_ctrl && wdata_i[`RVG_CTRL_START_BIT];
    assign stop_cmd = wr_ctrl && wdata_i[`RVG_CTRL_STOP_BIT] && !wdata_i[`RVG_CTRL_START_BIT];
    assign value_rd = rd_i && (addr_i == `RVG_ADDR_VALUE);

    rvg_slow_tick #(
        .DIV(SLOW_DIV)
    ) u_tick (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .tick_o(slow_tick)
    );

    // bus writes with data bit 0 set stir the sequence on a coinciding slow tick so runs differ between boots
    rvg_lfsr u_lfsr (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .step_i(slow_tick),
        .stir_i(wr_i & wdata_i[0]),
        .state_o(lfsr_q)
    );

    // sequencing
    always @* begin
        next_state = state;
        produce = 1'b0;
        case (state)
            ST_IDLE: begin
                next_state = ST_IDLE;
            end
            ST_WAIT, ST_RUN: begin
                // value taken on a slow-domain tick once the period expired
                if (period_cnt == 32'h0000_0000 && slow_tick) begin
                    produce = 1'b1;
                    if (mode == `RVG_ONE_VALUE_MODE) begin
                        next_state = ST_IDLE;
                    end else begin
                        next_state = ST_RUN;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (start_cmd) begin
            next_state = ST_WAIT;
            produce = 1'b0;
        end else if (stop_cmd) begin
            next_state = ST_IDLE;
            produce = 1'b0;
        end
    end

    always @* begin
        next_value = value;
        if (produce) begin
            next_value = lfsr_q;
        end
    end

    // flag and events: a new value wins over a clear in the same cycle
    always @* begin
        next_avail = avail;
        next_irq_stat = irq_stat;
        if (start_cmd || value_rd) begin
            next_avail = 1'b0;
            next_irq_stat[`RVG_IRQ_NEW_BIT] = 1'b0;
        end
        if (wr_i && addr_i == `RVG_ADDR_IRQ_CLR) begin
            next_irq_stat = next_irq_stat & ~wdata_i[1:0];
        end
        if (produce) begin
            next_avail = 1'b1;
            if (avail) begin
                next_irq_stat[`RVG_IRQ_OVR_BIT] = 1'b1;
            end
            // sticky event always recorded; the enable only gates the line
            next_irq_stat[`RVG_IRQ_NEW_BIT] = 1'b1;
        end
    end

    always @(posedge mclk_i) begin
        if (srst_i) begin
            state <= ST_IDLE;
            mode <= `RVG_ONE_VALUE_MODE;
            start_irq_en <= 1'b0;
            avail <= 1'b0;
            value <= 16'h0000;
            period_cnt <= 32'h0000_0000;
            irq_stat <= 2'b00;
            irq_en <= 2'b00;
            irq_o <= 1'b0;
            running_o <= 1'b0;
        end else begin
            state <= next_state;
            value <= next_value;
            avail <= next_avail;
            irq_stat <= next_irq_stat;
            irq_o <= |(next_irq_stat & irq_en);
            running_o <= (next_state != ST_IDLE);
            if (start_cmd) begin
                mode <= wdata_i[`RVG_CTRL_MODE_BIT];
                start_irq_en <= wdata_i[`RVG_CTRL_IRQEN_BIT];
                // the new-value event follows the enable given at start
                irq_en[`RVG_IRQ_NEW_BIT] <= wdata_i[`RVG_CTRL_IRQEN_BIT];
                period_cnt <= PERIOD_CYC - 1;
            end else if (produce) begin
                period_cnt <= PERIOD_CYC - 1;
            end else if (period_cnt != 32'h0000_0000) begin
                period_cnt <= period_cnt - 32'h0000_0001;
            end
            if (wr_i && addr_i == `RVG_ADDR_IRQ_EN) begin
                irq_en <= wdata_i[1:0];
            end
        end
    end

    // read port: one cycle latency; status read has no side effect
    always @(posedge mclk_i) begin
        if (srst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            case (addr_i)
                `RVG_ADDR_CTRL: begin
                    rdata_o <= {28'h0000000, start_irq_en, mode, 2'b00};
                end
                `RVG_ADDR_STAT: begin
                    rdata_o <= {29'h00000000, mode, (state != ST_IDLE), avail};
                end
                `RVG_ADDR_VALUE: begin
                    rdata_o <= rvg_word(value);
                end
                `RVG_ADDR_IRQ_STAT: begin
                    rdata_o <= {30'h00000000, irq_stat};
                end
                `RVG_ADDR_IRQ_EN: begin
                    rdata_o <= {30'h00000000, irq_en};
                end
                default: begin
                    rdata_o <= 32'h0000_0000;
                end
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end
endmodule

// ---- tb/rvg_checker.sv ----
// port checker for the random value generator
// assumes the top module ports only
`timescale 1ns/1ps
module rvg_checker #(
    parameter PERIOD_CYC = 8,
    parameter SLOW_DIV = 4
) (
    // clock, reset, bus
    input wire mclk_i,
    input wire srst_i,
    input wire [7:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    // outputs
    input wire [31:0] rdata_o,
    input wire irq_o,
    input wire running_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    wire ctl = wr_i && addr_i == 8'h00;
    wire start = ctl && wdata_i[0];
    reg fr;
    reg [15:0] cnt;
    // one-value runs are bounded by period plus tick wait
    always @(posedge mclk_i) begin
        if (srst_i) fr <= 1'b0;
        else if (start) fr <= wdata_i[2];
        if (srst_i || start || !running_o || fr) cnt <= 16'h0;
        else cnt <= cnt + 16'h1;
    end
    sequence rd_val_s; rd_i && addr_i == 8'h08; endsequence
    sequence stop_s; ctl && wdata_i[1] && !wdata_i[0]; endsequence
    idle_zero_a: assert property (!rd_i |=> rdata_o == 32'h0) else $error("rdata not idle");
    value_width_a: assert property (rd_val_s |=> rdata_o[31:16] == 16'h0) else $error("value wide");
    start_runs_a: assert property (start |=> running_o) else $error("start ignored");
    stop_halts_a: assert property (stop_s |=> !running_o) else $error("stop ignored");
    start_clears_a: assert property (start |-> ##2 !irq_o) else $error("irq after start");
    read_clears_a: assert property (rd_val_s ##0 !running_o |-> ##2 !irq_o) else $error("irq kept");
    oneshot_bound_a: assert property (cnt <= PERIOD_CYC + SLOW_DIV + 3) else $error("no halt");
    freerun_stays_a: assert property ($fell(running_o) && fr |-> $past(ctl && wdata_i[1])) else $error("halted");
endmodule
bind rvg_top rvg_checker #(.PERIOD_CYC(PERIOD_CYC), .SLOW_DIV(SLOW_DIV)) u_chk (.mclk_i(mclk_i),
    .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .running_o(running_o));

// ---- tb/rvg_tb_top.sv ----
// self-checking bench for the random value generator
// assumes short period and divider parameters
`timescale 1ns/1ps
module rvg_tb_top;
    localparam P = 8;
    localparam D = 4;
    reg mclk_i = 1'b0;
    reg srst_i = 1'b1;
    reg [7:0] addr_i = 8'h00;
    reg [31:0] wdata_i = 32'h0;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    wire [31:0] rdata_o;
    wire irq_o;
    wire running_o;
    integer num_errors = 0;
    integer n_checks = 0;
    integer cyc = 0;
    integer t0, i, k;
    reg [31:0] d, v;
    rvg_top #(.PERIOD_CYC(P), .SLOW_DIV(D)) u_dut (.mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .running_o(running_o));
    initial forever #20 mclk_i = ~mclk_i;
    always @(posedge mclk_i) cyc <= cyc + 1;
    function [31:0] exp_ctrl(input m, input e);
        exp_ctrl = {28'h0, e, m, 2'b00};
    endfunction
    task chk(input [47:0] nm, input [31:0] e, input [31:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("ERROR %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] w);
        begin
            @(posedge mclk_i);
            addr_i <= a;
            wdata_i <= w;
            wr_i <= 1'b1;
            @(posedge mclk_i);
            wr_i <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge mclk_i);
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge mclk_i);
            rd_i <= 1'b0;
            #1 d = rdata_o;
        end
    endtask
    task idle(input integer n);
        begin
            repeat (n) @(posedge mclk_i);
            #1;
        end
    endtask
    task wait_irq;
        begin
            for (k = 0; irq_o !== 1'b1 && k < 4 * (P + D); k = k + 1) idle(1);
            chk("irq", 1, irq_o);
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d errors %0d", n_checks, num_errors);
            if (num_errors == 0 && n_checks > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask
    // watchdog sized well above the expected run
    initial begin
        #(40 * 8000);
        num_errors = num_errors + 1;
        print_verdict;
    end
    initial begin
        v = $urandom(32'h1618);
        repeat (4) @(posedge mclk_i);
        srst_i <= 1'b0;
        for (i = 0; i < 4; i = i + 1) begin
            rd(i * 4 + (i > 1) * 4);
            chk("reset", 0, d);
        end
        rd(8'h20 | ($urandom & 8'h1c));
        chk("unmap", 0, d);
        $display("test reset done");
        wr(8'h00, 32'h9);
        wait_irq;
        rd(8'h04);
        v = d;
        rd(8'h04);
        chk("poll", v, d);
        chk("avail", 1, d[0]);
        rd(8'h08);
        v = d;
        chk("upper", 0, d[31:16]);
        rd(8'h08);
        chk("value", v, d);
        rd(8'h04);
        chk("avail", 0, d[0]);
        idle(3 * (P + D));
        chk("run", 0, running_o);
        rd(8'h0c);
        chk("istat", 0, d);
        $display("test one_value done");
        wr(8'h00, 32'h1);
        for (k = 0; d[0] !== 1'b1 && k < 40; k = k + 1) rd(8'h04);
        chk("avail", 1, d[0]);
        chk("irq", 0, irq_o);
        wr(8'h10, 32'h1);
        idle(2);
        chk("irq", 1, irq_o);
        wr(8'h14, 32'h1);
        idle(2);
        chk("irq", 0, irq_o);
        $display("test poll done");
        wr(8'h00, 32'hd);
        t0 = cyc;
        rd(8'h00);
        chk("ctrl", exp_ctrl(1, 1), d);
        for (i = 0; i < 4; i = i + 1) begin
            wait_irq;
            chk("gap", 1, cyc - t0 >= P && cyc - t0 <= P + D + 3);
            t0 = cyc;
            rd(8'h08);
            idle(2);
        end
        wr(8'h00, 32'h2);
        idle(1);
        chk("run", 0, running_o);
        wr(8'h14, 32'h3);
        idle(3 * (P + D));
        rd(8'h0c);
        chk("istat", 0, d);
        $display("test free_run done");
        for (i = 0; i < 6; i = i + 1) begin
            v = $urandom;
            wr(8'h08, v);
            wr(8'h00, {28'h0, v[3:2], 2'b01});
            rd(8'h00);
            chk("ctrl", exp_ctrl(v[2], v[3]), d);
            rd(8'h10);
            chk("irqen", v[3], d[0]);
            wr(8'h00, 32'h2);
            wr(8'h14, 32'h3);
        end
        $display("test random done");
        print_verdict;
    end
endmodule
